// file: src/dmt_cfg.svh
`ifndef DMT_CFG_SVH
`define DMT_CFG_SVH

// Register indices; byte address is four times the index
`define DMT_IDX_T1_LO 16'h7FA0
`define DMT_IDX_T1_HI 16'h7FA1
`define DMT_IDX_T2_LO 16'h7FA2
`define DMT_IDX_T2_HI 16'h7FA3
`define DMT_IDX_CTRL 16'h7FA4
`define DMT_IDX_CLKSET 16'h7FB6
`define DMT_IDX_T1_WORD 16'h7FA8
`define DMT_IDX_T2_WORD 16'h7FA9
`define DMT_IDX_IRQ_STAT 16'h7FAA
`define DMT_IDX_IRQ_MASK 16'h7FAB
`define DMT_IDX_T1_COUNT 16'h7FAC
`define DMT_IDX_T2_COUNT 16'h7FAD

// Control register field positions, per timer base
`define DMT_CTRL_T1_BASE 0
`define DMT_CTRL_T2_BASE 4
`define DMT_CTRL_IE_OFS 0
`define DMT_CTRL_FLG_OFS 1
`define DMT_CTRL_CKSL_OFS 2
`define DMT_CTRL_RUN_OFS 3

// Clock setting register fields
`define DMT_CLK_FOREIGN_BIT 0
`define DMT_CLK_CK_LSB 2
`define DMT_CLK_CK_MSB 3
`define DMT_CLK_PR_LSB 4
`define DMT_CLK_PR_MSB 7

// Reset values
`define DMT_RST_BYTE 8'h00
`define DMT_RST_WORD 16'h0000
`define DMT_RST_NIB 4'h0

// Interrupt vectors of the two timer requests
`define DMT_VEC_T1 16'h8024
`define DMT_VEC_T2 16'h8030

// System clock period in ns
`define DMT_CLK_PERIOD_NS 50

`endif

// file: src/dmt_pkg.sv
`default_nettype none
package dmt_pkg;
  // Prescaler count clock sources
  typedef enum logic [1:0] {
    DMT_CK_SYS = 2'b00,
    DMT_CK_RSV = 2'b01,
    DMT_CK_LFO = 2'b10,
    DMT_CK_MAIN = 2'b11
  } dmt_pck_t;
  typedef logic [15:0] dmt_word_t;
  typedef logic [7:0] dmt_byte_t;
  typedef logic [31:0] dmt_bus_t;
endpackage : dmt_pkg
`default_nettype wire

// file: src/dmt_tmr_if.sv
`default_nettype none
// Signals between the register side and one timer
interface dmt_tmr_if;
  logic run;
  logic clk_sel;
  logic tick;
  logic [15:0] match_data;
  logic match;
  logic toggle;
  logic [15:0] count;
  logic [15:0] buffer;
  modport ctl (output run, clk_sel, tick, match_data, input match, toggle, count, buffer);
  modport tmr (input run, clk_sel, tick, match_data, output match, toggle, count, buffer);
endinterface : dmt_tmr_if
`default_nettype wire

// file: src/dmt_prescaler.sv
`include "dmt_cfg.svh"
`default_nettype none
module dmt_prescaler (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire dmt_pkg::dmt_pck_t src_i,
  input wire logic [3:0] period_i,
  // Oscillator levels, synchronous to clock_i
  input wire logic low_osc_i,
  input wire logic main_osc_i,
  // Match pulse
  output logic match_o
);
  import dmt_pkg::*;

  logic [3:0] count;
  logic low_prev;
  logic main_prev;
  logic count_en;

  // Rising edges of the slow sources act as count enables
  assign count_en = (src_i == DMT_CK_SYS) ? 1'b1 :
                    (src_i == DMT_CK_LFO) ? (low_osc_i & ~low_prev) :
                    (src_i == DMT_CK_MAIN) ? (main_osc_i & ~main_prev) : 1'b0;
  assign match_o = run_i && count_en && (count == period_i);

  // Edge history of the oscillators
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_prev <= 1'b0;
      main_prev <= 1'b0;
    end else begin
      low_prev <= low_osc_i;
      main_prev <= main_osc_i;
    end
  end

  // Counter clears when stopped or on match
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= `DMT_RST_NIB;
    end else if (!run_i || match_o) begin
      count <= `DMT_RST_NIB;
    end else if (count_en) begin
      count <= count + 4'h1;
    end
  end
endmodule : dmt_prescaler
`default_nettype wire

// file: src/dmt_timer.sv
`include "dmt_cfg.svh"
`default_nettype none
module dmt_timer (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register side
  dmt_tmr_if.tmr tif
);
  import dmt_pkg::*;

  dmt_word_t count;
  dmt_word_t buffer;
  logic out_low;
  logic count_en;
  logic hit;

  // Count clock is the system clock or the prescaler pulse
  assign count_en = tif.clk_sel ? tif.tick : 1'b1;
  assign hit = tif.run && count_en && (count == buffer);
  assign tif.match = hit;
  assign tif.count = count;
  assign tif.buffer = buffer;
  assign tif.toggle = ~out_low;

  // Count up; period is match value plus one
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= `DMT_RST_WORD;
    end else if (!tif.run || hit) begin
      count <= `DMT_RST_WORD;
    end else if (count_en) begin
      count <= count + 16'h0001;
    end
  end

  // Match buffer follows data when stopped, reloads on match
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buffer <= `DMT_RST_WORD;
    end else if (!tif.run || hit) begin
      buffer <= tif.match_data;
    end
  end

  // Stored inverted so reset gives a high output
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_low <= 1'b0;
    end else if (!tif.run) begin
      out_low <= 1'b0;
    end else if (hit) begin
      out_low <= ~out_low;
    end
  end
endmodule : dmt_timer
`default_nettype wire

// file: src/dmt_top.sv
// Notes on behaviour
// - Run bits 3 and 7; stop holds zero
// - Select bits 2 and 6 choose clock
// - Match pulse when count equals buffer
// - Counters clear when stopped or matched
// - Buffer tracks data stopped, reloads matched
// - Flag sets on running match, stays
// - Flag and enable request the interrupt
// - Prescaler runs while any select set
// - Prescaler source code; 01 not used
// - Prescaler pulses every period plus one
// - Output high stopped, toggles on match
// - Match data byte and word access
// - Clock setting bit 1 reads zero
// - Clock setting bit 0 has no effect
// - Timer period is match plus one
//
// Chosen here: the APB register port.
`include "dmt_cfg.svh"
`default_nettype none
module dmt_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire dmt_pkg::dmt_bus_t paddr_i,
  input wire dmt_pkg::dmt_bus_t pwdata_i,
  input wire logic [3:0] pstrb_i,
  output dmt_pkg::dmt_bus_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Oscillator levels, synchronous to clock_i
  input wire logic low_frequency_oscillator_i,
  input wire logic main_oscillator_i,
  // Timer outputs
  output logic first_timer_toggle_out_o,
  output logic second_timer_toggle_out_o,
  // Interrupt requests
  output logic first_timer_irq_o,
  output logic second_timer_irq_o,
  output logic irq_o,
  // Stored bit owned by another module
  output logic foreign_pwm_clock_bit_o
);
  import dmt_pkg::*;

  localparam int NT = 2;
  localparam logic [15:0] LO_IDX [NT] = '{`DMT_IDX_T1_LO, `DMT_IDX_T2_LO};
  localparam logic [15:0] HI_IDX [NT] = '{`DMT_IDX_T1_HI, `DMT_IDX_T2_HI};
  localparam logic [15:0] WD_IDX [NT] = '{`DMT_IDX_T1_WORD, `DMT_IDX_T2_WORD};
  localparam logic [15:0] CT_IDX [NT] = '{`DMT_IDX_T1_COUNT, `DMT_IDX_T2_COUNT};
  localparam int CT_BASE [NT] = '{`DMT_CTRL_T1_BASE, `DMT_CTRL_T2_BASE};

  // Address decode against a register index
  function automatic logic dmt_hit(input dmt_bus_t addr, input logic [15:0] idx);
    return (addr[31:2] == {14'h0, idx}) && (addr[1:0] == 2'b00);
  endfunction : dmt_hit

  // Byte placement on the read bus
  function automatic dmt_bus_t dmt_byte(input dmt_byte_t val);
    return {24'h000000, val};
  endfunction : dmt_byte

  // Register state
  dmt_byte_t match_lo [NT];
  dmt_byte_t match_hi [NT];
  logic [NT-1:0] run;
  logic [NT-1:0] clk_sel;
  logic [NT-1:0] flag;
  logic [NT-1:0] irq_en;
  logic [3:0] pre_period;
  dmt_pck_t pre_src;
  logic foreign_bit;
  logic [NT-1:0] irq_stat;
  logic [NT-1:0] irq_mask;
  dmt_bus_t rdata;
  logic slverr;

  // Bus phase strobes
  logic setup_rd;
  logic setup_any;
  logic wr_acc;
  logic hit_ctrl;
  logic hit_clk;
  logic hit_stat;
  logic hit_mask;
  logic [NT-1:0] hit_lo;
  logic [NT-1:0] hit_hi;
  logic [NT-1:0] hit_wd;
  logic [NT-1:0] hit_ct;
  logic any_hit;
  logic lane0;
  logic lane1;

  assign setup_any = psel_i && !penable_i;
  assign setup_rd = setup_any && !pwrite_i;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign lane0 = pstrb_i[0];
  assign lane1 = pstrb_i[1];

  // Fixed register decode
  assign hit_ctrl = dmt_hit(paddr_i, `DMT_IDX_CTRL);
  assign hit_clk = dmt_hit(paddr_i, `DMT_IDX_CLKSET);
  assign hit_stat = dmt_hit(paddr_i, `DMT_IDX_IRQ_STAT);
  assign hit_mask = dmt_hit(paddr_i, `DMT_IDX_IRQ_MASK);
  assign any_hit = hit_ctrl | hit_clk | hit_stat | hit_mask |
                   (|hit_lo) | (|hit_hi) | (|hit_wd) | (|hit_ct);

  // Timer links and prescaler
  dmt_tmr_if tif [NT] ();
  logic pre_run;
  logic pre_match;
  logic [NT-1:0] t_match;
  logic [NT-1:0] t_toggle;
  dmt_word_t t_count [NT];

  assign pre_run = |clk_sel;

  dmt_prescaler u_pre (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .run_i(pre_run),
    .src_i(pre_src),
    .period_i(pre_period),
    .low_osc_i(low_frequency_oscillator_i),
    .main_osc_i(main_oscillator_i),
    .match_o(pre_match)
  );

  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_tmr
      // Per-timer decode
      assign hit_lo[t] = dmt_hit(paddr_i, LO_IDX[t]);
      assign hit_hi[t] = dmt_hit(paddr_i, HI_IDX[t]);
      assign hit_wd[t] = dmt_hit(paddr_i, WD_IDX[t]);
      assign hit_ct[t] = dmt_hit(paddr_i, CT_IDX[t]);

      // Byte writes: from a byte register or a word lane
      logic wr_lo;
      logic wr_hi;
      logic ctl_wr;
      dmt_byte_t ctl_byte;
      assign wr_lo = wr_acc && (hit_lo[t] ? lane0 : (hit_wd[t] && lane0));
      assign wr_hi = wr_acc && (hit_hi[t] ? lane0 : (hit_wd[t] && lane1));
      assign ctl_wr = wr_acc && hit_ctrl && lane0;
      assign ctl_byte = pwdata_i[7:0];

      // Link to the timer
      assign tif[t].run = run[t];
      assign tif[t].clk_sel = clk_sel[t];
      assign tif[t].tick = pre_match;
      assign tif[t].match_data = {match_hi[t], match_lo[t]};
      assign t_match[t] = tif[t].match;
      assign t_toggle[t] = tif[t].toggle;
      assign t_count[t] = tif[t].count;

      dmt_timer u_tmr (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tif(tif[t])
      );

      // Match data bytes
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          match_lo[t] <= `DMT_RST_BYTE;
          match_hi[t] <= `DMT_RST_BYTE;
        end else begin
          if (wr_lo) begin
            match_lo[t] <= pwdata_i[7:0];
          end
          if (wr_hi) begin
            match_hi[t] <= hit_wd[t] ? pwdata_i[15:8] : pwdata_i[7:0];
          end
        end
      end

      // Control bits of this timer
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          run[t] <= 1'b0;
          clk_sel[t] <= 1'b0;
          irq_en[t] <= 1'b0;
        end else if (ctl_wr) begin
          run[t] <= ctl_byte[CT_BASE[t] + `DMT_CTRL_RUN_OFS];
          clk_sel[t] <= ctl_byte[CT_BASE[t] + `DMT_CTRL_CKSL_OFS];
          irq_en[t] <= ctl_byte[CT_BASE[t] + `DMT_CTRL_IE_OFS];
        end
      end

      // Match flag: a running match sets it, a written zero clears it
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          flag[t] <= 1'b0;
        end else if (t_match[t]) begin
          flag[t] <= 1'b1;
        end else if (ctl_wr && !ctl_byte[CT_BASE[t] + `DMT_CTRL_FLG_OFS]) begin
          flag[t] <= 1'b0;
        end
      end

      // Sticky event status, write one to clear, set wins
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          irq_stat[t] <= 1'b0;
        end else if (t_match[t]) begin
          irq_stat[t] <= 1'b1;
        end else if (wr_acc && hit_stat && lane0 && pwdata_i[t]) begin
          irq_stat[t] <= 1'b0;
        end
      end
    end
  endgenerate

  // Clock setting register; bit 0 is only stored
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_period <= `DMT_RST_NIB;
      pre_src <= DMT_CK_SYS;
      foreign_bit <= 1'b0;
    end else if (wr_acc && hit_clk && lane0) begin
      pre_period <= pwdata_i[`DMT_CLK_PR_MSB:`DMT_CLK_PR_LSB];
      pre_src <= dmt_pck_t'(pwdata_i[`DMT_CLK_CK_MSB:`DMT_CLK_CK_LSB]);
      foreign_bit <= pwdata_i[`DMT_CLK_FOREIGN_BIT];
    end
  end

  // Interrupt mask
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask <= 2'b00;
    end else if (wr_acc && hit_mask && lane0) begin
      irq_mask <= pwdata_i[NT-1:0];
    end
  end

  // Read data selection
  dmt_byte_t ctrl_rd;
  dmt_byte_t clk_rd;
  dmt_bus_t rd_mux;
  assign ctrl_rd = {run[1], clk_sel[1], flag[1], irq_en[1],
                    run[0], clk_sel[0], flag[0], irq_en[0]};
  assign clk_rd = {pre_period, pre_src, 1'b0, foreign_bit};
  assign rd_mux = hit_lo[0] ? dmt_byte(match_lo[0]) :
                  hit_hi[0] ? dmt_byte(match_hi[0]) :
                  hit_lo[1] ? dmt_byte(match_lo[1]) :
                  hit_hi[1] ? dmt_byte(match_hi[1]) :
                  hit_wd[0] ? {16'h0000, match_hi[0], match_lo[0]} :
                  hit_wd[1] ? {16'h0000, match_hi[1], match_lo[1]} :
                  hit_ct[0] ? {16'h0000, t_count[0]} :
                  hit_ct[1] ? {16'h0000, t_count[1]} :
                  hit_ctrl ? dmt_byte(ctrl_rd) :
                  hit_clk ? dmt_byte(clk_rd) :
                  hit_stat ? {30'h0, irq_stat} :
                  hit_mask ? {30'h0, irq_mask} : 32'h00000000;

  // Read data and error captured in the setup cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata <= 32'h00000000;
      slverr <= 1'b0;
    end else if (setup_any) begin
      rdata <= setup_rd ? rd_mux : 32'h00000000;
      slverr <= !any_hit;
    end
  end

  // Bus answers: no wait states
  assign pready_o = 1'b1;
  assign prdata_o = rdata;
  assign pslverr_o = slverr && psel_i && penable_i;

  // Outputs
  assign first_timer_toggle_out_o = t_toggle[0];
  assign second_timer_toggle_out_o = t_toggle[1];
  assign first_timer_irq_o = flag[0] & irq_en[0];
  assign second_timer_irq_o = flag[1] & irq_en[1];
  assign irq_o = |(irq_stat & irq_mask);
  assign foreign_pwm_clock_bit_o = foreign_bit;
endmodule : dmt_top
`default_nettype wire

// file: bench/dmt_checker_sva.sv
`include "dmt_cfg.svh"
`default_nettype none
module dmt_checker (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire dmt_pkg::dmt_bus_t paddr_i,
  input wire dmt_pkg::dmt_bus_t pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire dmt_pkg::dmt_bus_t prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Timer pins
  input wire logic first_timer_toggle_out_o,
  input wire logic second_timer_toggle_out_o,
  input wire logic first_timer_irq_o,
  input wire logic second_timer_irq_o,
  input wire logic irq_o,
  input wire logic foreign_pwm_clock_bit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import dmt_pkg::*;
  logic acc;
  logic ok;
  logic wr0;
  logic [15:0] idx;
  logic [7:0] ctl;
  logic [1:0] msk;
  logic fb;
  // Access phase and address map decode
  assign acc = psel_i && penable_i;
  assign idx = paddr_i[17:2];
  assign ok = paddr_i[31:18] == 14'h0 && paddr_i[1:0] == 2'h0 && (idx inside
    {[`DMT_IDX_T1_LO:`DMT_IDX_CTRL], [`DMT_IDX_T1_WORD:`DMT_IDX_T2_COUNT], `DMT_IDX_CLKSET});
  assign wr0 = acc && pwrite_i && pstrb_i[0] && ok;
  // Shadow of software written control bits
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl <= 8'h00;
      msk <= 2'h0;
      fb <= 1'b0;
    end else if (wr0) begin
      if (idx == `DMT_IDX_CTRL) ctl <= pwdata_i[7:0];
      if (idx == `DMT_IDX_IRQ_MASK) msk <= pwdata_i[1:0];
      if (idx == `DMT_IDX_CLKSET) fb <= pwdata_i[0];
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // Stop request for the first timer
  sequence stop1_s;
    wr0 && idx == `DMT_IDX_CTRL && !pwdata_i[3];
  endsequence
  // Interrupt rising with enable already set
  sequence rise1_s;
    $rose(first_timer_irq_o) && $past(ctl[0]);
  endsequence
  err_map_a: assert property (acc |-> pslverr_o == !ok)
    else $error("slave error does not follow address map");
  err_phase_a: assert property (pslverr_o |-> acc)
    else $error("slave error outside access phase");
  ready_now_a: assert property (acc |-> pready_o)
    else $error("access phase without ready");
  bit_one_zero_a: assert property (
    acc && !pwrite_i && ok && idx == `DMT_IDX_CLKSET |-> prdata_o[31:8] == 24'h0 && !prdata_o[1])
    else $error("clock setting read shows unused bits");
  foreign_bit_a: assert property (foreign_pwm_clock_bit_o == fb)
    else $error("foreign bit differs from written value");
  stop_high_a: assert property (stop1_s |=> ##1 first_timer_toggle_out_o)
    else $error("first output not high after stop");
  hold_one_a: assert property (!ctl[3] && !$past(ctl[3]) |-> first_timer_toggle_out_o)
    else $error("first output low while stopped");
  hold_two_a: assert property (!ctl[7] && !$past(ctl[7]) |-> second_timer_toggle_out_o)
    else $error("second output low while stopped");
  fall_run_a: assert property ($fell(first_timer_toggle_out_o) |-> $past(ctl[3]))
    else $error("first output fell while stopped");
  irq_gate_a: assert property (first_timer_irq_o |-> ctl[0])
    else $error("first request without enable");
  irq2_gate_a: assert property (second_timer_irq_o |-> ctl[4])
    else $error("second request without enable");
  irq_mask_a: assert property (irq_o |-> msk != 2'h0)
    else $error("summary interrupt with all masked");
  flag_match_a: assert property (rise1_s |-> $changed(first_timer_toggle_out_o))
    else $error("flag set without a match");
endmodule : dmt_checker
`default_nettype wire

// file: bench/dual_match_timer_with_prescaler_tb.sv
`include "dmt_cfg.svh"
`default_nettype none
module dual_match_timer_with_prescaler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dmt_pkg::*;
  localparam logic [15:0] I_CTL = `DMT_IDX_CTRL;
  localparam logic [15:0] I_CLK = `DMT_IDX_CLKSET;
  localparam logic [15:0] I_W1 = `DMT_IDX_T1_WORD;
  localparam logic [15:0] I_ST = `DMT_IDX_IRQ_STAT;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, perr, osc_lo = 1'b0, osc_hi = 1'b0;
  logic [3:0] pstrb = 4'hF;
  logic tog1, tog2, irq1, irq2, irq, fbit;
  logic [15:0] seed = 16'h3910;
  logic [31:0] r;
  logic e;
  int err_total, check_count, cyc, m, n, t0, t1;
  int mdl [16'h7FA0:16'h7FB6];
  // Clock, cycle count and oscillator levels
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    osc_lo <= ~osc_lo;
    if (cyc[0]) osc_hi <= ~osc_hi;
  end
  dmt_top DUT (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .low_frequency_oscillator_i(osc_lo), .main_oscillator_i(osc_hi),
    .first_timer_toggle_out_o(tog1), .second_timer_toggle_out_o(tog2),
    .first_timer_irq_o(irq1), .second_timer_irq_o(irq2), .irq_o(irq),
    .foreign_pwm_clock_bit_o(fbit));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Model read value; word registers combine the byte pair
  function automatic int expv(input logic [15:0] ix);
    int lo;
    lo = `DMT_IDX_T1_LO + 2 * (ix - I_W1);
    if (ix inside {I_W1, `DMT_IDX_T2_WORD}) return mdl[lo] | (mdl[lo + 1] << 8);
    return mdl[ix];
  endfunction : expv
  task automatic stop_test;
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
    int k;
    k = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {14'h0, ix, 2'h0};
    pwdata <= wd;
    @(posedge clock_i);
    pen <= 1'b1;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 50) chk(k, 0);
  endtask : apb
  // Write and update the register model
  task automatic wr(input logic [15:0] ix, input int d);
    logic [31:0] rd;
    logic er;
    int lo;
    apb(1'b1, ix, d, rd, er);
    lo = `DMT_IDX_T1_LO + 2 * (ix - I_W1);
    case (ix)
      I_CTL: mdl[ix] = (d & 8'hDD) | (d & mdl[ix] & 8'h22);
      I_CLK: mdl[ix] = d & 8'hFD;
      I_ST: mdl[ix] = mdl[ix] & ~d;
      I_W1, `DMT_IDX_T2_WORD: begin
        if (pstrb[0]) mdl[lo] = d & 8'hFF;
        if (pstrb[1]) mdl[lo + 1] = (d >> 8) & 8'hFF;
      end
      default: mdl[ix] = d & 8'hFF;
    endcase
  endtask : wr
  task automatic rdc(input logic [15:0] ix);
    logic [31:0] rd;
    logic er;
    apb(1'b0, ix, 32'h0, rd, er);
    chk(rd, expv(ix));
  endtask : rdc
  // Wait for a toggle output to change, return the cycle stamp
  task automatic wait_tog(input int s, output int t);
    logic v;
    int k;
    v = s ? tog2 : tog1;
    k = 0;
    while ((s ? tog2 : tog1) === v && k < 4000) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= 4000) chk(k, 0);
    t = cyc;
  endtask : wait_tog
  // Watchdog
  initial begin
    #1000000;
    err_total++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 16'h7FA0; i <= 16'h7FAE; i++) begin
      apb(1'b0, 16'(i), 32'h0, r, e);
      chk(r, 32'h0);
      chk(e, i inside {[16'h7FA5:16'h7FA7], 16'h7FAE});
    end
    rdc(I_CLK);
    chk({tog2, tog1, irq2, irq1, irq}, 5'h18);
    // Random byte and word writes read back both ways
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(16'(16'h7FA0 + i), seed[7:0]);
    end
    seed = lfsr(seed);
    wr(`DMT_IDX_T2_WORD, seed);
    // Word write on the high lane only
    pstrb <= 4'h2;
    seed = lfsr(seed);
    wr(I_W1, seed);
    pstrb <= 4'hF;
    for (int i = 0; i < 10; i++) rdc(16'(16'h7FA0 + i));
    wr(I_CLK, 8'hFF);
    rdc(I_CLK);
    chk(fbit, 1'b1);
    // First timer on system clock, reload while running
    seed = lfsr(seed);
    m = seed[2:0] + 6;
    wr(I_W1, m);
    wr(I_CTL, 8'h0B);
    wait_tog(0, t0);
    wait_tog(0, t1);
    chk(t1 - t0, m + 1);
    chk(irq1, 1'b1);
    wr(I_W1, m + 5);
    wait_tog(0, t0);
    chk(t0 - t1, m + 1);
    wait_tog(0, t1);
    chk(t1 - t0, m + 6);
    mdl[I_CTL] |= 2;
    mdl[I_ST] |= 1;
    wr(I_CTL, 8'h03);
    repeat (2) @(posedge clock_i);
    chk(tog1, 1'b1);
    rdc(`DMT_IDX_T1_COUNT);
    rdc(I_CTL);
    rdc(I_ST);
    wr(`DMT_IDX_IRQ_MASK, 1);
    @(posedge clock_i);
    chk(irq, 1'b1);
    wr(I_ST, 1);
    wr(I_CTL, 8'h01);
    @(posedge clock_i);
    chk({irq, irq1}, 2'h0);
    rdc(I_CTL);
    // Second timer on the prescaler for every source code
    // Both timers on the prescaler; match data only written while stopped
    wr(16'h7FA2, 1);
    wr(16'h7FA3, 0);
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      n = seed[1:0] + 1;
      wr(I_CLK, n << 4 | c << 2 | 1);
      wr(I_CTL, 8'h44);
      wr(I_CTL, 8'hEC);
      if (c == 1) begin
        repeat (100) @(posedge clock_i);
        chk({tog2, tog1}, 2'h3);
      end else begin
        wait_tog(1, t0);
        wait_tog(1, t1);
        chk(t1 - t0, 2 * (n + 1) * (1 << (c - c / 2)));
        wait_tog(0, t0);
        wait_tog(0, t1);
        chk(t1 - t0, (m + 6) * (n + 1) * (1 << (c - c / 2)));
        chk(irq2, 1'b0);
      end
      wr(I_CTL, 8'h44);
    end
    wr(I_CTL, 8'h00);
    stop_test();
  end
endmodule : dual_match_timer_with_prescaler_tb
bind dmt_top dmt_checker chk_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .first_timer_toggle_out_o(first_timer_toggle_out_o),
  .second_timer_toggle_out_o(second_timer_toggle_out_o),
  .first_timer_irq_o(first_timer_irq_o), .second_timer_irq_o(second_timer_irq_o),
  .irq_o(irq_o), .foreign_pwm_clock_bit_o(foreign_pwm_clock_bit_o));
`default_nettype wire
